// file: rtl/lcsr_consts.svh
// Constants for the link controller host register port: bit positions,
// pointer fields, primitive codes and timing counts.
// Assumes inclusion by its bare name from every design file that needs it.
`ifndef LCSR_CONSTS_SVH
`define LCSR_CONSTS_SVH

// Address pointer fields
`define LCSR_PTR_NARROW      7
`define LCSR_PTR_SEL_HI     3
`define LCSR_PTR_SEL_LO     1
`define LCSR_PTR_UPPER      0
`define LCSR_PTR_RESET      16'h0000

// Register select codes
`define LCSR_SEL_CTRL       3'h0
`define LCSR_SEL_PRIM       3'h1

// Control/status bits
`define LCSR_B_POLL         15
`define LCSR_B_STOP         14
`define LCSR_B_TXDIS        13
`define LCSR_B_RXDIS        12
`define LCSR_B_TRANSMIT_RING_ACTIVE         11
`define LCSR_B_RECEIVE_RING_ACTIVE         10
`define LCSR_B_IGATE        9
`define LCSR_B_ISUM         8
`define LCSR_FLAG_HI        7
`define LCSR_FLAG_LO        1

// Primitive exchange bits
`define LCSR_B_CONFLICT     15
`define LCSR_B_PENDING      14
`define LCSR_B_PARAM        13
`define LCSR_CODE_HI        12
`define LCSR_CODE_LO        8

// Host primitive codes
`define LCSR_PRIM_STOP      5'h00
`define LCSR_PRIM_START     5'h01

// Bus master ready timeout, in system clocks
`define LCSR_TIMEOUT_CYC    256
`endif

// file: rtl/lcsr_pkg.sv
// Types shared by the link controller host register port.
// Assumes lcsr_consts.svh is available for the numeric constants.
package lcsr_pkg;

  // Events raised by the link engine, one cycle pulses
  typedef struct packed {
    logic busTimeout;   // flag bit 7
    logic rxMissed;     // flag bit 6
    logic rxOverflow;   // flag bit 5
    logic txStarved;    // flag bit 4
    logic provEvent;    // flag bit 3
    logic txDone;       // flag bit 2
    logic rxDone;       // flag bit 1
  } lcsr_events_type;

  // Steering toward the link engine
  typedef struct packed {
    logic       stopped;
    logic       txRingActive;
    logic       rxRingActive;
    logic       pollRequest;
    logic       localBusy;
    logic       sendReady;
    logic       cmdValid;
    logic [4:0] cmdCode;
    logic       cmdParam;
  } lcsr_ctrl_type;

  // Host command engine states
  typedef enum logic [2:0] {
    LCSR_CMD_IDLE = 3'b001,
    LCSR_CMD_EXEC = 3'b010,
    LCSR_CMD_DONE = 3'b100
  } lcsr_cmd_state_type;

endpackage

// file: rtl/lcsr_flag_bank.sv
// Sticky event flags with write-one-to-clear and a summary output.
// Assumes single clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
`include "lcsr_consts.svh"

module lcsr_flag_bank #(
  parameter int NFLAGS = 7
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire logic [NFLAGS-1:0] setPulse,
  input  wire logic [NFLAGS-1:0] clearOnes,
  input  wire logic              clearAll,
  output logic      [NFLAGS-1:0] flags,
  output logic                   anyFlag
);

  // Refuse widths that do not fit the 16-bit register view
  if (NFLAGS < 1 || NFLAGS > 15) begin : gBadParam
    $error("lcsr_flag_bank: NFLAGS out of range");
  end

  logic [NFLAGS-1:0] flag_r;

  // Each flag: set beats host clear so no event is lost
  genvar i;
  generate
    for (i = 0; i < NFLAGS; i++) begin : gFlag
      logic flag_nxt;
      // (RL13) set-only clear-by-one
      assign flag_nxt = setPulse[i] | (flag_r[i] & ~clearOnes[i] & ~clearAll);
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          flag_r[i] <= 1'b0;
        end else if (clkEn) begin
          flag_r[i] <= flag_nxt;
        end
      end
    end
  endgenerate

  assign flags   = flag_r;
  // (RL11) summary is OR of flags
  assign anyFlag = |flag_r;

  flag_set_wins_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL13)
    clkEn && setPulse[0] |=> flag_r[0])
    else $error("flag set lost against clear");

endmodule
`default_nettype wire

// file: rtl/lcsr_host_port.sv
// Host register port: address pointer, data window, control/status and
// primitive exchange registers of the link controller.
// Assumes host bus signals synchronous to ref_clk; link engine drives events.
`timescale 1ns/1ps
`default_nettype none
`include "lcsr_consts.svh"

// How it works
// (RL1) Port-select low reaches data window, high reaches address pointer.
// (RL2) Host writes zero to reserved pointer bits and byte select when wide.
// (RL3) Pointer bit 7 picks byte mode; bit 0 picks upper byte.
// (RL4) Pointer bits 3:1 choose the register; reset clears pointer.
// (RL5) Data window writes load and reads return the selected register.
// (RL6) Poll request set by writing one, cleared when used or reset.
// (RL7) Stop bit set by reset or stop command; held until start.
// (RL8) Transmit disable stops transmit ring access after current frame.
// (RL9) Receive disable stops receive ring; local busy RNR, clear sends RR.
// (RL10) Ring active bits follow start, disables, stop and reset.
// (RL11) Summary is OR of flags; interrupt low when gate and summary set.
// (RL12) Ready missing for 256 clocks sets timeout flag, turns rings off.
// (RL13) Event flags set by device, cleared by one, reset or stop.
// (RL14) Missed frame sets flag, clears receive ring, busy until cleared.
// (RL15) Receive overflow sets flag; engine flushes and reuses buffers.
// (RL16) Transmit starvation mid-frame sets underrun flag.
// (RL17) New provider event written sets provider flag.
// (RL18) Transmit descriptor update sets transmit done flag.
// (RL19) Receive descriptor update sets receive done flag.
// (RL20) Conflicting host command sets conflict bit; clear by writing one.
// (RL21) Host writes code and parameter then pending; device clears pending.
// (RL22) Code 0 stops (param 1 full reset); code 1 starts when stopped.
module lcsr_host_port (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     clkEn,
  input  wire logic                     busSel,
  input  wire logic                     portSelect,
  input  wire logic                     busWrite,
  input  wire logic [15:0]              busWdata,
  input  wire lcsr_pkg::lcsr_events_type events,
  input  wire logic                     pollTaken,
  input  wire logic                     linkUp,
  input  wire logic                     transparentMode,
  input  wire logic                     masterAddrValid,
  input  wire logic                     masterReady,
  input  wire logic [7:0]               provPrimData,
  output logic      [15:0]              busRdata,
  output logic                          interruptLow,
  output lcsr_pkg::lcsr_ctrl_type       ctrl
);

  // Register state
  logic [15:0] ptr_r;
  logic        poll_r, stop_r, txDis_r, rxDis_r, transmit_ring_active_r, receive_ring_active_r, gate_r;
  logic        conflict_r, pending_r, param_r;
  logic [4:0]  code_r;
  logic [8:0]  waitCnt_r;
  logic        busyPrev_r;
  logic [15:0] rdata_r;
  logic        irq_r;
  lcsr_pkg::lcsr_ctrl_type ctrl_r;
  lcsr_pkg::lcsr_cmd_state_type st_r, st_nxt;

  // Byte lane merge for narrow mode, used by control and primitive register writes
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic narrow, input logic upper);
    if (!narrow) begin
      merge = wd;
    end else if (upper) begin
      merge = {wd[7:0], old[7:0]};
    end else begin
      merge = {old[15:8], wd[7:0]};
    end
  endfunction

  // (RL1) decode by port-select level
  wire         ptrWr   = clkEn & busSel & busWrite & portSelect;
  wire         winWr   = clkEn & busSel & busWrite & ~portSelect;
  // (RL3) width and byte select from pointer
  wire         narrow  = ptr_r[`LCSR_PTR_NARROW];
  wire         upper   = ptr_r[`LCSR_PTR_UPPER] & narrow;
  // (RL4) register select field
  wire  [2:0]  regSel  = ptr_r[`LCSR_PTR_SEL_HI:`LCSR_PTR_SEL_LO];
  wire         ctrlWr  = winWr & (regSel == `LCSR_SEL_CTRL);
  wire         primWr  = winWr & (regSel == `LCSR_SEL_PRIM);

  // Event flags and summary view
  logic [6:0]  flags;
  logic        anyFlag;
  wire  [15:0] ctrlOld;
  wire  [15:0] primOld;
  wire  [15:0] ctrlW   = merge(ctrlOld, busWdata, narrow, upper);
  wire  [15:0] primW   = merge(primOld, busWdata, narrow, upper);
  // Narrow writes touch one lane; the merged-in old byte must not act on
  // write-one-to-clear or write-one-to-set bits
  wire         hiLane  = ~narrow | upper;
  wire         loLane  = ~narrow | ~upper;
  wire  [6:0]  flagClr = (ctrlWr & loLane) ? ctrlW[`LCSR_FLAG_HI:`LCSR_FLAG_LO] : 7'h00;

  // Command decode
  wire         cmdExec  = (st_r == lcsr_pkg::LCSR_CMD_EXEC);
  wire         isStop   = cmdExec & (code_r == `LCSR_PRIM_STOP);
  wire         isStart  = cmdExec & (code_r == `LCSR_PRIM_START);
  // (RL22) start valid only stopped or transparent
  wire         startOk  = stop_r | transparentMode;
  wire         badCmd   = cmdExec & ((isStart & ~startOk) |
                          ((code_r != `LCSR_PRIM_STOP) & (code_r != `LCSR_PRIM_START)));
  wire         doStop   = isStop;
  wire         doStart  = isStart & startOk;
  wire         softRst  = doStop & param_r;

  // (RL12) bus master ready timeout
  wire         timeout  = masterAddrValid & ~masterReady &
                          (waitCnt_r == 9'(`LCSR_TIMEOUT_CYC - 1));
  // (RL15) overflow sets flag
  // (RL16) starvation sets flag
  // (RL17) provider event flag
  // (RL18) transmit done flag
  // (RL19) receive done flag
  wire [6:0]   flagSet  = {events.busTimeout | timeout, events.rxMissed,
                           events.rxOverflow, events.txStarved, events.provEvent,
                           events.txDone, events.rxDone};

  lcsr_flag_bank #(
    .NFLAGS (7)
  ) uFlags (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .setPulse  (flagSet),
    .clearOnes (flagClr),
    .clearAll  (doStop),
    .flags     (flags),
    .anyFlag   (anyFlag)
  );

  // Register views as the host reads them; control register bit 0 reads zero
  assign ctrlOld = {poll_r, stop_r, txDis_r, rxDis_r, transmit_ring_active_r, receive_ring_active_r, gate_r,
                    anyFlag, flags, 1'b0};
  assign primOld = {conflict_r, pending_r, param_r, code_r, provPrimData};

  // (RL5) window read selects register
  wire  [15:0] winWord = (regSel == `LCSR_SEL_CTRL) ? ctrlOld :
                         (regSel == `LCSR_SEL_PRIM) ? primOld : 16'h0000;
  wire  [15:0] winRead = !narrow ? winWord :
                         upper   ? {8'h00, winWord[15:8]} : {8'h00, winWord[7:0]};
  wire  [15:0] rdNext  = portSelect ? ptr_r : winRead;

  // Local busy: receive disabled or missed frame while link is up
  // (RL9) busy from disable
  // (RL14) busy from missed frame
  wire         busyNow = linkUp & (rxDis_r | flags[5]);

  // (RL4) pointer write; reserved bits are kept zero regardless of host
  always_ff @(posedge ref_clk) begin
    if (rst || (clkEn && softRst)) begin
      ptr_r <= `LCSR_PTR_RESET;
    end else if (ptrWr) begin
      ptr_r <= busWdata & 16'h008f;
    end
  end

  // Control register write side and device updates
  always_ff @(posedge ref_clk) begin
    if (rst || (clkEn && softRst)) begin
      poll_r  <= 1'b0;
      stop_r  <= 1'b1;
      txDis_r <= 1'b0;
      rxDis_r <= 1'b0;
      gate_r  <= 1'b0;
    end else if (clkEn) begin
      // (RL6) poll: one sets, use clears
      poll_r  <= (ctrlWr & hiLane & ctrlW[`LCSR_B_POLL]) | (poll_r & ~pollTaken);
      // (RL7) stop set by stop command
      stop_r  <= doStop ? 1'b1 : doStart ? 1'b0 : stop_r;
      txDis_r <= ctrlWr ? ctrlW[`LCSR_B_TXDIS] : txDis_r;
      rxDis_r <= ctrlWr ? ctrlW[`LCSR_B_RXDIS] : rxDis_r;
      // (RL11) gate blocked while stopped
      gate_r  <= doStop ? 1'b0 :
                 ctrlWr ? (ctrlW[`LCSR_B_IGATE] & ~stop_r) : gate_r;
    end
  end

  // Ring active bits; a disable or an error beats start in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst || (clkEn && softRst)) begin
      transmit_ring_active_r <= 1'b0;
      receive_ring_active_r <= 1'b0;
    end else if (clkEn) begin
      // (RL8) transmit ring stops on disable
      // (RL10) active bits follow start
      // (RL12) timeout turns rings off
      // A timeout keeps both rings off until the host clears its flag or a start is accepted
      transmit_ring_active_r <= ~doStop & ~txDis_r & ~timeout & ~events.busTimeout &
                (transmit_ring_active_r | doStart | (~stop_r & ~flags[6]));
      // (RL14) missed frame clears receive ring
      receive_ring_active_r <= ~doStop & ~rxDis_r & ~timeout & ~events.busTimeout & ~events.rxMissed &
                (receive_ring_active_r | doStart | (~stop_r & ~flags[5] & ~flags[6]));
    end
  end

  // (RL12) count clocks from address until ready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitCnt_r <= 9'h000;
    end else if (clkEn) begin
      waitCnt_r <= (masterAddrValid & ~masterReady & ~timeout) ? waitCnt_r + 9'h001 : 9'h000;
    end
  end

  // Host command state machine
  always_comb begin
    case (st_r)
      lcsr_pkg::LCSR_CMD_IDLE: st_nxt = pending_r ? lcsr_pkg::LCSR_CMD_EXEC : st_r;
      lcsr_pkg::LCSR_CMD_EXEC: st_nxt = lcsr_pkg::LCSR_CMD_DONE;
      lcsr_pkg::LCSR_CMD_DONE: st_nxt = lcsr_pkg::LCSR_CMD_IDLE;
      default:                 st_nxt = lcsr_pkg::LCSR_CMD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= lcsr_pkg::LCSR_CMD_IDLE;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // Primitive exchange register
  always_ff @(posedge ref_clk) begin
    if (rst || (clkEn && softRst)) begin
      conflict_r <= 1'b0;
      pending_r  <= 1'b0;
      param_r    <= 1'b0;
      code_r     <= 5'h00;
    end else if (clkEn) begin
      // (RL20) conflict set wins over clear
      conflict_r <= badCmd | (conflict_r & ~(primWr & hiLane & primW[`LCSR_B_CONFLICT]));
      // (RL21) pending cleared once processed
      if (st_r == lcsr_pkg::LCSR_CMD_DONE) begin
        pending_r <= 1'b0;
      end else if (primWr && st_r == lcsr_pkg::LCSR_CMD_IDLE) begin
        pending_r <= primW[`LCSR_B_PENDING];
      end
      if (primWr && st_r == lcsr_pkg::LCSR_CMD_IDLE) begin
        param_r <= primW[`LCSR_B_PARAM];
        code_r  <= primW[`LCSR_CODE_HI:`LCSR_CODE_LO];
      end
    end
  end

  // Registered outputs: read data, interrupt pin, engine steering
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r    <= 16'h0000;
      irq_r      <= 1'b1;
      busyPrev_r <= 1'b0;
      ctrl_r     <= '0;
    end else if (clkEn) begin
      rdata_r    <= rdNext;
      // (RL11) pin low when gate and summary
      irq_r      <= ~(gate_r & anyFlag);
      busyPrev_r <= busyNow;
      ctrl_r.stopped      <= stop_r;
      ctrl_r.txRingActive <= transmit_ring_active_r;
      ctrl_r.rxRingActive <= receive_ring_active_r;
      ctrl_r.pollRequest  <= poll_r;
      ctrl_r.localBusy    <= busyNow;
      ctrl_r.sendReady    <= busyPrev_r & ~busyNow & linkUp;
      // (RL22) command handed to link engine
      ctrl_r.cmdValid     <= cmdExec & ~badCmd;
      ctrl_r.cmdCode      <= code_r;
      ctrl_r.cmdParam     <= param_r;
    end
  end

  assign busRdata     = rdata_r;
  assign interruptLow = irq_r;
  assign ctrl         = ctrl_r;

  gate_needs_run_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL11)
    clkEn && stop_r && !doStop |=> !$rose(gate_r))
    else $error("interrupt gate set while stopped");
  irq_pin_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL11)
    clkEn |=> (irq_r == !($past(gate_r) && $past(anyFlag))))
    else $error("interrupt pin does not follow gate and summary");
  stop_clears_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL10)
    clkEn && doStop && flagSet == 7'h00 |=> stop_r && !transmit_ring_active_r && !receive_ring_active_r && flags == 7'h00)
    else $error("stop did not clear ring and flag state");
  timeout_flag_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL12)
    clkEn && timeout |=> flags[6] && !transmit_ring_active_r && !receive_ring_active_r)
    else $error("bus timeout did not set flag or stop rings");
  txdis_off_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL8)
    clkEn && txDis_r |=> !transmit_ring_active_r)
    else $error("transmit ring active while disabled");
  pending_done_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL21)
    clkEn && st_r == lcsr_pkg::LCSR_CMD_DONE |=> !pending_r)
    else $error("pending not cleared after command");
  poll_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL6)
    clkEn && poll_r && !pollTaken && !softRst |=> poll_r)
    else $error("poll request dropped before use");
  ptr_write_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL4)
    ptrWr && !softRst |=> ptr_r == ($past(busWdata) & 16'h008f))
    else $error("pointer write not stored");
  conflict_set_a: assert property (@(posedge ref_clk) disable iff (rst) // (RL20)
    clkEn && badCmd |=> conflict_r)
    else $error("conflict not flagged");

  cov_start_c: cover property (@(posedge ref_clk) disable iff (rst) doStart);
  cov_stop_c: cover property (@(posedge ref_clk) disable iff (rst) doStop);
  cov_irq_c: cover property (@(posedge ref_clk) disable iff (rst) !irq_r);
  cov_timeout_c: cover property (@(posedge ref_clk) disable iff (rst) timeout);

endmodule
`default_nettype wire

// file: sim/lcsr_host_model.sv
// Host processor model: slave accesses to the pointer and window ports.
// Assumes accesses are taken on a ref_clk edge with busSel high.
`timescale 1ns/1ps
`default_nettype none

module lcsr_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] busRdata,
  output var  logic        busSel,
  output var  logic        portSelect,
  output var  logic        busWrite,
  output var  logic [15:0] busWdata
);
  // Idle bus at time zero
  initial begin
    busSel = 1'b0;
    portSelect = 1'b1;
    busWrite = 1'b0;
    busWdata = 16'h0000;
  end

  // One access held until its taking edge
  // pin level picks pointer or window
  task automatic access(input logic ptr, input logic wr, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    busSel = 1'b1;
    portSelect = ptr;
    busWrite = wr;
    busWdata = d;
    @(posedge ref_clk);
    #1;
    busSel = 1'b0;
    busWrite = 1'b0;
    busWdata = ~d; // Released data must not look still valid
  endtask

  task automatic wr_reg(input logic ptr, input logic [15:0] d);
    access(ptr, 1'b1, d);
  endtask

  // Answer is registered at the taking edge and stands until the next one
  task automatic rd_reg(input logic ptr, output logic [15:0] q);
    access(ptr, 1'b0, 16'h0000);
    q = busRdata;
  endtask

  // code, parameter and pending written together
  // pointer written with reserved bits zero
  task automatic command(input logic [4:0] code, input logic param);
    wr_reg(1'b1, 16'h0002);
    wr_reg(1'b0, {2'b01, param, code, 8'h00});
  endtask
endmodule

`default_nettype wire

// file: sim/test_lcsr_host_port.sv
// Self-checking bench for the host register port, random and corner cases.
// Assumes lcsr_host_model drives the host bus; the bench drives the engine.
`timescale 1ns/1ps
`default_nettype none
`include "lcsr_consts.svh"

module test_lcsr_host_port;
  logic                      ref_clk;
  logic                      rst;
  logic                      clkEn;
  logic                      busSel;
  logic                      portSelect;
  logic                      busWrite;
  logic [15:0]               busWdata;
  lcsr_pkg::lcsr_events_type events;
  logic                      pollTaken;
  logic                      linkUp;
  logic                      transparentMode;
  logic                      masterAddrValid;
  logic                      masterReady;
  logic [7:0]                provPrimData;
  logic [15:0]               busRdata;
  logic                      interruptLow;
  lcsr_pkg::lcsr_ctrl_type   ctrlOut;
  logic [15:0]               q;
  logic [15:0]               v;
  logic [4:0]                mask;
  int                        bad_count = 0;
  int                        cmp_count = 0;
  int                        cycles = 0;
  int                        rrSeen = 0;
  int                        cmdSeen = 0;

  lcsr_host_port dut (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .busSel(busSel),
    .portSelect(portSelect), .busWrite(busWrite), .busWdata(busWdata),
    .events(events), .pollTaken(pollTaken), .linkUp(linkUp),
    .transparentMode(transparentMode), .masterAddrValid(masterAddrValid),
    .masterReady(masterReady), .provPrimData(provPrimData),
    .busRdata(busRdata), .interruptLow(interruptLow), .ctrl(ctrlOut)
  );

  lcsr_host_model host (
    .ref_clk(ref_clk), .busRdata(busRdata), .busSel(busSel),
    .portSelect(portSelect), .busWrite(busWrite), .busWdata(busWdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Count one-cycle engine strobes; they are gone before a read returns
  always @(negedge ref_clk) begin
    rrSeen += int'(ctrlOut.sendReady);
    cmdSeen += int'(ctrlOut.cmdValid);
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Run is a few hundred cycles; the ceiling catches a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Running state with gate set and both rings on, plus event flags
  function automatic logic [15:0] run_ctrl(input logic [6:0] fl);
    return {6'b000011, 1'b1, |fl, fl, 1'b0};
  endfunction

  task automatic sel(input logic [2:0] r);
    host.wr_reg(1'b1, {12'h000, r, 1'b0});
  endtask

  task automatic pulse(input logic [6:0] p);
    @(posedge ref_clk);
    #1;
    events = lcsr_pkg::lcsr_events_type'(p);
    @(posedge ref_clk);
    #1;
    events = '0;
  endtask

  // Bounded wait for the command engine to drop pending
  task automatic wait_cmd();
    logic [15:0] r;
    int          n;
    n = 0;
    r = 16'h4000;
    while (r[`LCSR_B_PENDING] !== 1'b0 && n < 20) begin
      host.rd_reg(1'b0, r);
      n++;
    end
    check({15'h0000, r[`LCSR_B_PENDING]}, 16'h0000);
    v = r;
  endtask

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    events = '0;
    pollTaken = 1'b0;
    linkUp = 1'b0;
    transparentMode = 1'b0;
    masterAddrValid = 1'b0;
    masterReady = 1'b1;
    provPrimData = 8'h00;
    void'($urandom(32'hd3bd));
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    provPrimData = 8'($urandom);
    // Reset state of pointer, stop bit and interrupt pin
    host.rd_reg(1'b1, q);
    check(q, 16'h0000);
    host.rd_reg(1'b0, q);
    check(q, 16'h4000);
    check({15'h0000, interruptLow}, 16'h0001);
    // Random pointer values; reserved bits must not stick
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      host.wr_reg(1'b1, v);
      host.rd_reg(1'b1, q);
      check(q, v & 16'h008f);
    end
    sel(3'h0);
    // Gate cannot be set while stopped
    host.wr_reg(1'b0, 16'h0200);
    host.rd_reg(1'b0, q);
    check(q, 16'h4000);
    // Start, then provider byte and rings
    host.command(`LCSR_PRIM_START, 1'b0);
    wait_cmd();
    check(v, {8'h01, provPrimData});
    sel(3'h0);
    host.wr_reg(1'b0, 16'h0200);
    host.rd_reg(1'b0, q);
    check(q, run_ctrl(7'h00));
    // Random event sets, write-zero hold, write-one clear
    for (int i = 0; i < 4; i++) begin
      mask = 5'($urandom_range(1, 31));
      pulse({2'b00, mask});
      host.wr_reg(1'b0, 16'h0200);
      host.rd_reg(1'b0, q);
      check(q, run_ctrl({2'b00, mask}));
      check({15'h0000, interruptLow}, 16'h0000);
      host.wr_reg(1'b0, {10'h008, mask, 1'b0});
      host.rd_reg(1'b0, q);
      check(q, run_ctrl(7'h00));
      check({15'h0000, interruptLow}, 16'h0001);
    end
    // Poll request held until taken
    host.wr_reg(1'b0, 16'h8200);
    host.rd_reg(1'b0, q);
    check(q, run_ctrl(7'h00) | 16'h8000);
    check({15'h0000, ctrlOut.pollRequest}, 16'h0001);
    @(posedge ref_clk);
    #1;
    pollTaken = 1'b1;
    @(posedge ref_clk);
    #1;
    pollTaken = 1'b0;
    host.rd_reg(1'b0, q);
    check(q, run_ctrl(7'h00));
    // Ring disables with a link up
    linkUp = 1'b1;
    host.wr_reg(1'b0, 16'h3200);
    host.rd_reg(1'b0, q);
    check(q, 16'h3200);
    check({15'h0000, ctrlOut.localBusy}, 16'h0001);
    host.wr_reg(1'b0, 16'h0200);
    host.rd_reg(1'b0, q);
    check(q, run_ctrl(7'h00));
    check({15'h0000, ctrlOut.localBusy}, 16'h0000);
    // Missed frame drops the receive ring
    pulse(7'b0100000);
    host.rd_reg(1'b0, q);
    check(q, 16'h0b40);
    check({15'h0000, ctrlOut.localBusy}, 16'h0001);
    host.wr_reg(1'b0, 16'h0240);
    host.rd_reg(1'b0, q);
    check(q, run_ctrl(7'h00));
    linkUp = 1'b0;
    // Ready withheld: no flag before 256 clocks, flag after
    masterReady = 1'b0;
    masterAddrValid = 1'b1;
    repeat (240) @(posedge ref_clk);
    host.rd_reg(1'b0, q);
    check(q & 16'h0080, 16'h0000);
    repeat (30) @(posedge ref_clk);
    host.rd_reg(1'b0, q);
    check(q & 16'h0180, 16'h0180);
    masterAddrValid = 1'b0;
    masterReady = 1'b1;
    host.wr_reg(1'b0, 16'h0280);
    host.rd_reg(1'b0, q);
    check(q & 16'h0380, 16'h0200);
    // Start while running is a conflict
    host.command(`LCSR_PRIM_START, 1'b0);
    wait_cmd();
    check(v, {8'h81, provPrimData});
    host.wr_reg(1'b0, 16'h0000);
    host.rd_reg(1'b0, q);
    check(q, {8'h80, provPrimData});
    host.wr_reg(1'b0, 16'h8000);
    host.rd_reg(1'b0, q);
    check(q, {8'h00, provPrimData});
    // Stop clears flags, gate and rings
    pulse(7'b0000001);
    host.command(`LCSR_PRIM_STOP, 1'b0);
    wait_cmd();
    sel(3'h0);
    host.rd_reg(1'b0, q);
    check(q, 16'h4000);
    check({15'h0000, ctrlOut.stopped}, 16'h0001);
    check({15'h0000, interruptLow}, 16'h0001);
    // Narrow mode byte reads
    host.wr_reg(1'b1, 16'h0081);
    host.rd_reg(1'b0, q);
    check(q, 16'h0040);
    // Upper-lane write sets both disables, lower byte untouched
    host.wr_reg(1'b0, 16'h0030);
    host.rd_reg(1'b0, q);
    check(q, 16'h0070);
    host.wr_reg(1'b1, 16'h0080);
    host.rd_reg(1'b0, q);
    check(q, 16'h0000);
    // Unmapped select reads zero and ignores writes
    host.wr_reg(1'b1, 16'h0004);
    host.wr_reg(1'b0, 16'hffff);
    host.rd_reg(1'b0, q);
    check(q, 16'h0000);
    // Busy ended twice with the link up; start and stop reached the engine
    check(16'(rrSeen), 16'h0002);
    check(16'(cmdSeen), 16'h0002);
    end_sim();
  end
endmodule

`default_nettype wire
